// [prot_pkg.sv]
// constants for the chip protection and boot option block
package prot_pkg;
    localparam logic [7:0] prot_ctrl_addr = 8'hda;
    localparam logic [7:0] prot_ctrl_reset = 8'h20;
    localparam int full_lock_bit = 7;
    localparam int debug_off_bit = 6;
    localparam int reserved_bit = 5;
    localparam int multi_lock_bit = 4;
    localparam int write_lock_bit = 3;
    localparam int level_lsb = 0;
    localparam int level_msb = 2;
    localparam logic [2:0] level_factory = 3'h1;
    localparam logic [2:0] level_user = 3'h3;
    localparam logic [2:0] level_run = 3'h7;
    localparam int opt_retest_nv_bit = 7;
    localparam int opt_early_osc_bit = 4;
    localparam int opt_auto_run_bit = 1;
    localparam logic [7:0] multi_read_blocked = 8'h00;
endpackage : prot_pkg

// [chip_protection_boot_options.sv]
// protection control register and boot option sequencing
`timescale 1ns/1ps
`default_nettype none
module chip_protection_boot_options
    import prot_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // boot sequencer
    input wire logic boot_start,
    input wire logic [7:0] nv_prot_value,
    input wire logic [7:0] boot_option_byte,
    input wire logic copy_done,
    input wire logic wake_from_shutdown,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // memory and debug requests
    input wire logic nv_rd_req,
    input wire logic nv_wr_req,
    input wire logic [7:0] multi_rdata_raw,
    input wire logic debug_req,
    // outputs
    output logic [7:0] chip_protection_control,
    output logic crystal_osc_enable,
    output logic copy_start,
    output logic run_user_code,
    output logic boot_done,
    output logic nv_rd_allow,
    output logic nv_wr_allow,
    output logic multi_enable,
    output logic [7:0] multi_rdata,
    output logic debug_allow
);
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_osc = 3'b001,
        st_load = 3'b010,
        st_copy = 3'b011,
        st_final = 3'b100,
        st_done = 3'b101
    } boot_state_type;

    boot_state_type state_q, state_d;
    logic [7:0] prot_q, prot_d;
    logic osc_q, osc_d, copy_q, copy_d, run_q, run_d, done_q, done_d;
    logic nv_rd_q, nv_rd_d, nv_wr_q, nv_wr_d;
    logic multi_en_q, multi_en_d, debug_q, debug_d;
    logic [7:0] multi_rdata_q, multi_rdata_d;
    logic sw_wr;

    assign sw_wr = reg_wr && (reg_addr == prot_ctrl_addr);

    always_comb begin
        state_d = state_q;
        prot_d = prot_q;
        osc_d = osc_q;
        copy_d = 1'b0;
        run_d = run_q;
        done_d = done_q;
        // wake clears debug disable first so a same-cycle set still wins
        if (wake_from_shutdown) begin
            prot_d[debug_off_bit] = 1'b0;
        end
        // software can only set bits; stored copy is never written
        if (sw_wr) begin
            prot_d = prot_d | reg_wdata;
        end
        unique case (state_q)
            st_idle: begin
                if (boot_start) begin
                    state_d = st_osc;
                end
            end
            st_osc: begin
                if (boot_option_byte[opt_early_osc_bit]) begin
                    osc_d = 1'b1;
                end
                state_d = st_load;
            end
            st_load: begin
                prot_d = prot_d | nv_prot_value;
                copy_d = 1'b1;
                state_d = st_copy;
            end
            st_copy: begin
                if (copy_done) begin
                    state_d = st_final;
                end
            end
            st_final: begin
                if (boot_option_byte[opt_retest_nv_bit]) begin
                    prot_d[full_lock_bit] = 1'b1;
                end
                // only a user part may auto-start; else copy only
                if (prot_q[level_msb:level_lsb] == level_user &&
                        boot_option_byte[opt_auto_run_bit]) begin
                    run_d = 1'b1;
                end
                done_d = 1'b1;
                state_d = st_done;
            end
            st_done: begin
                state_d = st_done;
            end
            default: begin
                state_d = st_idle;
            end
        endcase
        prot_d[reserved_bit] = 1'b1;
    end

    always_comb begin
        nv_rd_d = !prot_d[full_lock_bit];
        nv_wr_d = !prot_d[full_lock_bit] &&
            !(prot_d[write_lock_bit] && prot_d[2:1] == 2'b11);
        multi_en_d = !prot_d[multi_lock_bit];
        multi_rdata_d = prot_d[multi_lock_bit] ? multi_read_blocked
                                              : multi_rdata_raw;
        debug_d = !prot_d[debug_off_bit];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= st_idle;
            prot_q <= prot_ctrl_reset;
            osc_q <= 1'b0;
            copy_q <= 1'b0;
            run_q <= 1'b0;
            done_q <= 1'b0;
            nv_rd_q <= 1'b1;
            nv_wr_q <= 1'b1;
            multi_en_q <= 1'b1;
            multi_rdata_q <= 8'h00;
            debug_q <= 1'b1;
        end else if (clk_en) begin
            state_q <= state_d;
            prot_q <= prot_d;
            osc_q <= osc_d;
            copy_q <= copy_d;
            run_q <= run_d;
            done_q <= done_d;
            nv_rd_q <= nv_rd_d;
            nv_wr_q <= nv_wr_d;
            multi_en_q <= multi_en_d;
            multi_rdata_q <= multi_rdata_d;
            debug_q <= debug_d;
        end
    end

    assign chip_protection_control = prot_q;
    assign crystal_osc_enable = osc_q;
    assign copy_start = copy_q;
    assign run_user_code = run_q;
    assign boot_done = done_q;
    assign nv_rd_allow = nv_rd_q;
    assign nv_wr_allow = nv_wr_q;
    assign multi_enable = multi_en_q;
    assign multi_rdata = multi_rdata_q;
    assign debug_allow = debug_q;

    property p_set_only;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !wake_from_shutdown) |=>
            ((prot_q & $past(prot_q)) == $past(prot_q));
    endproperty
    a_set_only: assert property (p_set_only)
        else $error("protection bit cleared");

    property p_write_sets;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && sw_wr) |=> ((prot_q & $past(reg_wdata)) ==
            $past(reg_wdata));
    endproperty
    a_write_sets: assert property (p_write_sets)
        else $error("written one not set");

    property p_reserved;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> prot_q[reserved_bit];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit not one");

    property p_full_lock;
        @(posedge ref_clk) disable iff (!rst_n)
        prot_q[full_lock_bit] |-> (!nv_rd_q && !nv_wr_q);
    endproperty
    a_full_lock: assert property (p_full_lock)
        else $error("memory access while locked");

    property p_debug_off;
        @(posedge ref_clk) disable iff (!rst_n)
        prot_q[debug_off_bit] |-> !debug_q;
    endproperty
    a_debug_off: assert property (p_debug_off)
        else $error("debug allowed while disabled");

    property p_multi;
        @(posedge ref_clk) disable iff (!rst_n)
        prot_q[multi_lock_bit] |-> (!multi_en_q && multi_rdata_q == 8'h00);
    endproperty
    a_multi: assert property (p_multi)
        else $error("multi memory not blocked");

    property p_write_lock;
        @(posedge ref_clk) disable iff (!rst_n)
        (!prot_q[full_lock_bit] && prot_q[write_lock_bit]) |->
            (nv_wr_q == (prot_q[2:1] != 2'b11));
    endproperty
    a_write_lock: assert property (p_write_lock)
        else $error("write lock level handling wrong");

    sequence s_final;
        clk_en && state_q == st_final;
    endsequence
    property p_auto_run;
        @(posedge ref_clk) disable iff (!rst_n)
        s_final ##0 (prot_q[2:0] != level_user) ##0 !run_q |=> !run_q;
    endproperty
    a_auto_run: assert property (p_auto_run)
        else $error("auto-run outside user level");

    property p_retest;
        @(posedge ref_clk) disable iff (!rst_n)
        s_final ##0 boot_option_byte[opt_retest_nv_bit] |=>
            (prot_q[full_lock_bit] && done_q);
    endproperty
    a_retest: assert property (p_retest)
        else $error("retest lock not set at end of boot");
endmodule : chip_protection_boot_options
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the protection and boot option block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import prot_pkg::*;
;
    logic ref_clk = 1'b0;
    logic en = 1'b1;
    logic rst_n = 1'b0;
    logic boot_start = 1'b0;
    logic copy_done = 1'b0;
    logic wake = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] nv_val = 8'h00, opt = 8'h00, addr = 8'h00, wdata = 8'h00;
    logic [7:0] raw = 8'h00;
    logic [2:0] req = 3'h0;
    logic [7:0] prot, mdata, exp_q;
    logic osc, cstart, run, done, rd_ok, wr_ok, m_en, dbg_ok;
    logic [31:0] seed = 32'h0000327f;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    chip_protection_boot_options dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(en), .boot_start(boot_start), .nv_prot_value(nv_val),
        .boot_option_byte(opt), .copy_done(copy_done),
        .wake_from_shutdown(wake), .reg_wr(reg_wr), .reg_addr(addr),
        .reg_wdata(wdata), .nv_rd_req(req[0]), .nv_wr_req(req[1]),
        .multi_rdata_raw(raw), .debug_req(req[2]),
        .chip_protection_control(prot), .crystal_osc_enable(osc),
        .copy_start(cstart), .run_user_code(run), .boot_done(done),
        .nv_rd_allow(rd_ok), .nv_wr_allow(wr_ok), .multi_enable(m_en),
        .multi_rdata(mdata), .debug_allow(dbg_ok));

    always #2 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic logic [3:0] allow_exp(input logic [7:0] r);
        logic wl;
        wl = r[write_lock_bit] & (r[2:1] == 2'h3);
        return {~r[full_lock_bit], ~(r[full_lock_bit] | wl),
                ~r[multi_lock_bit], ~r[debug_off_bit]};
    endfunction : allow_exp

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk8(input string what, input logic [7:0] e,
                        input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask : chk8

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic chk_all();
        chk8("register", exp_q, prot);
        chk8("allows", {4'h0, allow_exp(exp_q)},
             {4'h0, rd_ok, wr_ok, m_en, dbg_ok});
        chk8("memory data", exp_q[multi_lock_bit] ? multi_read_blocked : raw,
             mdata);
    endtask : chk_all

    task automatic boot(input logic [7:0] nv, input logic [7:0] op,
                        input logic exp_run);
        int k;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        nv_val <= nv;
        opt <= op;
        copy_done <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        exp_q = prot_ctrl_reset;
        settle(2);
        chk_all();
        @(posedge ref_clk);
        boot_start <= 1'b1;
        @(posedge ref_clk);
        boot_start <= 1'b0;
        k = 0;
        while (cstart !== 1'b1 && k < 20) begin
            settle(1);
            k++;
        end
        chk8("copy start", 8'h01, {7'h00, cstart});
        chk8("oscillator", {7'h00, op[opt_early_osc_bit]}, {7'h00, osc});
        @(posedge ref_clk);
        copy_done <= 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 20) begin
            settle(1);
            k++;
        end
        settle(1);
        exp_q = prot_ctrl_reset | nv;
        exp_q[full_lock_bit] = exp_q[full_lock_bit] | op[opt_retest_nv_bit];
        chk8("boot done", 8'h01, {7'h00, done});
        chk8("copy start", 8'h00, {7'h00, cstart});
        chk8("auto run", {7'h00, exp_run}, {7'h00, run});
        chk_all();
        $display("boot test done, stored %h options %h", nv, op);
    endtask : boot

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= d;
        seed = xs(seed);
        raw <= seed[15:8];
        req <= seed[2:0];
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a == prot_ctrl_addr) begin
            exp_q = exp_q | d | prot_ctrl_reset;
        end
        settle(2);
        chk_all();
    endtask : wr

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        boot(8'h03, 8'h12, 1'b1);
        wr(prot_ctrl_addr, 8'h08);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            wr((i % 5 == 0) ? seed[31:24] : prot_ctrl_addr,
               seed[7:0] & ((i < 20) ? 8'h1c : 8'hff));
        end
        wr(prot_ctrl_addr, 8'h40);
        wr(prot_ctrl_addr, 8'h00);
        $display("write test done");
        @(posedge ref_clk);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        exp_q[debug_off_bit] = 1'b0;
        settle(2);
        chk_all();
        $display("wake test done");
        // a write while the clock enable is low must leave all state frozen
        @(posedge ref_clk);
        en <= 1'b0;
        reg_wr <= 1'b1;
        addr <= prot_ctrl_addr;
        wdata <= 8'h40;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        settle(2);
        chk_all();
        @(posedge ref_clk);
        en <= 1'b1;
        $display("freeze test done");
        // set debug disable so the next reset has something to clear
        wr(prot_ctrl_addr, 8'h40);
        boot(8'h01, 8'h12, 1'b0);
        boot(8'h03, 8'h80, 1'b0);
        boot(8'h0f, 8'h02, 1'b0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
